/* hdl/dcs_regs.svh */
/*
  Constants of the debug control/status block: CSR address, field
  positions, fixed field values, entry causes and reset values.
  Assumes nothing; included by the two design modules, dcs_sync and dcs_ctrl.
*/
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH

// CSR address of the debug control/status register.
`define DCS_CSR_ADDR 12'h7B0

// Field positions.
`define DCS_VER_HI 31
`define DCS_VER_LO 28
`define DCS_EBRKM_BIT 15
`define DCS_EBRKS_BIT 13
`define DCS_EBRKU_BIT 12
`define DCS_STEPIE_BIT 11
`define DCS_STOPCNT_BIT 10
`define DCS_STOPTIME_BIT 9
`define DCS_CAUSE_HI 8
`define DCS_CAUSE_LO 6
`define DCS_MPRVEN_BIT 4
`define DCS_NMIP_BIT 3
`define DCS_STEP_BIT 2
`define DCS_PRV_HI 1
`define DCS_PRV_LO 0

// Fixed and reset values.
`define DCS_VERSION 4'h4
`define DCS_PRV_M 2'h3
`define DCS_ZERO_BIT 1'h0
`define DCS_WORD_ZERO 32'h0000_0000

// Entry cause encodings.
`define DCS_CAUSE_NONE 3'h0
`define DCS_CAUSE_EBREAK 3'h1
`define DCS_CAUSE_TRIGGER 3'h2
`define DCS_CAUSE_HALTREQ 3'h3
`define DCS_CAUSE_STEP 3'h4
`define DCS_CAUSE_RSTHALT 3'h5

// Cycles to wait after reset before the synchronised reset-halt level is trusted.
// The filtered level settles on the fourth edge after release, so the decision waits one more.
`define DCS_BOOT_WAIT 3'h4
`define DCS_BOOT_ZERO 3'h0
`define DCS_BOOT_ONE 3'h1

`endif

/* hdl/dcs_pkg.sv */
/*
  Types of the debug control/status block: hart state encoding and the
  state records of the two design modules.
  Assumes dcs_regs.svh is on the include path.
*/
package dcs_pkg;

  // Number of pin-level inputs passed through the synchroniser.
  localparam int DCS_SYNC_W = 3;

  typedef enum logic [1:0] {
    DCS_ST_RUN = 2'b00,
    DCS_ST_STEP = 2'b01,
    DCS_ST_HALT = 2'b10,
    DCS_ST_BOOT = 2'b11
  } dcs_state_e;

  typedef struct packed {
    logic [DCS_SYNC_W-1:0] ff1;
    logic [DCS_SYNC_W-1:0] ff2;
    logic [DCS_SYNC_W-1:0] ff3;
    logic [DCS_SYNC_W-1:0] level;
  } dcs_sync_s;

  typedef struct packed {
    dcs_state_e state;
    logic [2:0] boot_cnt;
    logic ebreakm;
    logic stepie;
    logic stopcount;
    logic step;
    logic [2:0] cause;
    logic [1:0] prv;
    logic [31:0] csr_rdata;
    logic csr_hit;
    logic csr_illegal;
    logic debug_mode;
    logic debug_entry;
    logic ebreak_to_debug;
    logic irq_block;
    logic count_stop;
    logic step_active;
  } dcs_core_s;

endpackage

/* hdl/dcs_sync.sv */
/*
  Three-stage synchroniser for pin-level inputs of the debug block.
  The output moves only once the second and third stages agree, which
  filters a single-cycle glitch. Assumes one clock and a synchronous reset.
*/
`timescale 1ns/1ps
`include "dcs_regs.svh"

module dcs_sync (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Levels from outside the clock domain
  input wire logic [dcs_pkg::DCS_SYNC_W-1:0] async_in,
  // Filtered levels
  output logic [dcs_pkg::DCS_SYNC_W-1:0] sync_out
);

  dcs_pkg::dcs_sync_s st;
  dcs_pkg::dcs_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.ff1 = async_in;
    next_st.ff2 = st.ff1;
    next_st.ff3 = st.ff2;
    for (int i = 0; i < dcs_pkg::DCS_SYNC_W; i++) begin
      if (st.ff2[i] == st.ff3[i]) begin
        next_st.level[i] = st.ff3[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign sync_out = st.level;

endmodule // dcs_sync

/* hdl/dcs_ctrl.sv */
/*
  Debug control/status register of a machine-mode-only hart with the
  halt, step and resume sequencing that feeds its entry cause.
  Assumes a core that reports ebreak, trigger hits, retirement and
  exceptions on this clock, and a debugger whose halt lines are pins.
*/
`timescale 1ns/1ps
`include "dcs_regs.svh"

// Function
// - Register reachable only in Debug Mode; machine-mode access flags illegal instruction.
// - Register decoded at CSR address 0x7B0.
// - Version field 31:28 always reads 4.
// - Bit 15 set makes machine-mode ebreak enter Debug Mode; resets to 0.
// - Supervisor and user ebreak enables, bits 13 and 12, read 0.
// - Bit 11 clear blocks interrupts while stepping, set allows them; resets 0.
// - Bit 10 set stops counters in Debug Mode and on entering ebreak.
// - Timer freeze bit 9 reads 0; timers keep running in Debug Mode.
// - Bits 8:6 hold entry cause: ebreak, trigger, haltreq, step, reset-halt.
// - Simultaneous causes: trigger, ebreak, reset-halt, haltreq, step, in that order.
// - Halt straight out of reset reports cause 5, or optionally 3.
// - Effective-privilege enable bit 4 reads 0.
// - Bit 3 shows a pending non-maskable interrupt.
// - Step bit set outside Debug Mode runs one instruction then halts.
// - Stepped instruction hitting an exception halts at once, before the handler.
// - Bits 1:0 hold privilege at entry, machine mode 3, reset value 3.
module dcs_ctrl #(
  parameter bit RESET_HALT_AS_HALTREQ = 1'b0
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // CSR access from the core
  input wire logic csr_rd,
  input wire logic csr_wr,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  output logic [31:0] csr_rdata,
  output logic csr_hit,
  output logic csr_illegal,
  // Halt requests from pins
  input wire logic dbg_halt_req,
  input wire logic multicore_debug_ctl_port_halt_req,
  input wire logic reset_halt_req,
  // Debugger resume, same clock
  input wire logic resume_req,
  // Core events, same clock
  input wire logic trigger_hit,
  input wire logic ebreak_exec,
  input wire logic instr_retired,
  input wire logic step_exception,
  input wire logic nmi_pending,
  // Hart control outputs
  output logic debug_mode,
  output logic debug_entry,
  output logic ebreak_to_debug,
  output logic irq_block,
  output logic count_stop,
  output logic step_active
);

  dcs_pkg::dcs_core_s st;
  dcs_pkg::dcs_core_s next_st;
  logic [dcs_pkg::DCS_SYNC_W-1:0] pins_sync;
  logic halt_req_s;
  logic rst_halt_s;

  // Pin requests are levels from the debugger's side and need filtering.
  dcs_sync u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in({reset_halt_req, multicore_debug_ctl_port_halt_req, dbg_halt_req}),
    .sync_out(pins_sync)
  );

  assign halt_req_s = pins_sync[0] | pins_sync[1];
  assign rst_halt_s = pins_sync[2];

  // Picks the highest-priority entry reason among those present.
  function automatic logic [2:0] pick_cause(
    input logic trig,
    input logic ebrk,
    input logic rsthalt,
    input logic halt,
    input logic stepdone
  );
    logic [2:0] c;
    c = `DCS_CAUSE_NONE;
    if (trig) begin
      c = `DCS_CAUSE_TRIGGER;
    end else if (ebrk) begin
      c = `DCS_CAUSE_EBREAK;
    end else if (rsthalt) begin
      c = RESET_HALT_AS_HALTREQ ? `DCS_CAUSE_HALTREQ : `DCS_CAUSE_RSTHALT;
    end else if (halt) begin
      c = `DCS_CAUSE_HALTREQ;
    end else if (stepdone) begin
      c = `DCS_CAUSE_STEP;
    end
    return c;
  endfunction

  // Assembles the register image; fixed fields are constants here.
  function automatic logic [31:0] read_image(
    input dcs_pkg::dcs_core_s s,
    input logic nmi
  );
    logic [31:0] v;
    v = `DCS_WORD_ZERO;
    v[`DCS_VER_HI:`DCS_VER_LO] = `DCS_VERSION;
    v[`DCS_EBRKM_BIT] = s.ebreakm;
    v[`DCS_EBRKS_BIT] = `DCS_ZERO_BIT;
    v[`DCS_EBRKU_BIT] = `DCS_ZERO_BIT;
    v[`DCS_STEPIE_BIT] = s.stepie;
    v[`DCS_STOPCNT_BIT] = s.stopcount;
    v[`DCS_STOPTIME_BIT] = `DCS_ZERO_BIT;
    v[`DCS_CAUSE_HI:`DCS_CAUSE_LO] = s.cause;
    v[`DCS_MPRVEN_BIT] = `DCS_ZERO_BIT;
    v[`DCS_NMIP_BIT] = nmi;
    v[`DCS_STEP_BIT] = s.step;
    v[`DCS_PRV_HI:`DCS_PRV_LO] = s.prv;
    return v;
  endfunction

  logic addr_match;
  logic acc_req;
  logic ebrk_take;
  logic step_done;
  logic [2:0] run_cause;

  assign addr_match = (csr_addr == `DCS_CSR_ADDR);
  assign acc_req = (csr_rd | csr_wr) & addr_match;

  always_comb begin
    next_st = st;
    next_st.csr_hit = 1'b0;
    next_st.csr_illegal = 1'b0;
    next_st.csr_rdata = `DCS_WORD_ZERO;
    next_st.debug_entry = 1'b0;
    ebrk_take = ebreak_exec & st.ebreakm;
    step_done = instr_retired | step_exception;
    run_cause = `DCS_CAUSE_NONE;

    unique case (st.state)
      dcs_pkg::DCS_ST_BOOT: begin
        // The synchroniser needs a few cycles before its level means anything.
        if (st.boot_cnt != `DCS_BOOT_WAIT) begin
          next_st.boot_cnt = st.boot_cnt + `DCS_BOOT_ONE;
        end else begin
          run_cause = pick_cause(1'b0, 1'b0, rst_halt_s, 1'b0, 1'b0);
          next_st.state = dcs_pkg::DCS_ST_RUN;
        end
      end
      dcs_pkg::DCS_ST_RUN: begin
        run_cause = pick_cause(trigger_hit, ebrk_take, 1'b0, halt_req_s, 1'b0);
      end
      dcs_pkg::DCS_ST_STEP: begin
        // A step ends on retirement or on an exception, whichever comes first.
        run_cause = pick_cause(trigger_hit, ebrk_take, 1'b0, halt_req_s, step_done);
      end
      dcs_pkg::DCS_ST_HALT: begin
        if (resume_req) begin
          next_st.state = st.step ? dcs_pkg::DCS_ST_STEP : dcs_pkg::DCS_ST_RUN;
        end
      end
    endcase

    if (run_cause != `DCS_CAUSE_NONE) begin
      next_st.state = dcs_pkg::DCS_ST_HALT;
      next_st.debug_entry = 1'b1;
      next_st.cause = run_cause;
      next_st.prv = `DCS_PRV_M;
    end

    if (acc_req) begin
      if (st.state == dcs_pkg::DCS_ST_HALT) begin
        next_st.csr_hit = 1'b1;
        if (csr_rd) begin
          next_st.csr_rdata = read_image(st, nmi_pending);
        end
        // Writes reach only the writable bits; the rest are rebuilt on read.
        if (csr_wr) begin
          next_st.ebreakm = csr_wdata[`DCS_EBRKM_BIT];
          next_st.stepie = csr_wdata[`DCS_STEPIE_BIT];
          next_st.stopcount = csr_wdata[`DCS_STOPCNT_BIT];
          next_st.step = csr_wdata[`DCS_STEP_BIT];
        end
      end else begin
        next_st.csr_illegal = 1'b1;
      end
    end

    next_st.debug_mode = (next_st.state == dcs_pkg::DCS_ST_HALT);
    next_st.step_active = (next_st.state == dcs_pkg::DCS_ST_STEP);
    next_st.ebreak_to_debug = next_st.ebreakm;
    next_st.irq_block = next_st.step_active & ~next_st.stepie;
    // Counting stops on the entering ebreak too, so its own retirement is not counted.
    next_st.count_stop = next_st.stopcount &
      (next_st.debug_mode | (ebrk_take & (st.state != dcs_pkg::DCS_ST_HALT)));
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st.state <= dcs_pkg::DCS_ST_BOOT;
      st.boot_cnt <= `DCS_BOOT_ZERO;
      st.ebreakm <= `DCS_ZERO_BIT;
      st.stepie <= `DCS_ZERO_BIT;
      st.stopcount <= `DCS_ZERO_BIT;
      st.step <= `DCS_ZERO_BIT;
      st.cause <= `DCS_CAUSE_NONE;
      st.prv <= `DCS_PRV_M;
      st.csr_rdata <= `DCS_WORD_ZERO;
      st.csr_hit <= `DCS_ZERO_BIT;
      st.csr_illegal <= `DCS_ZERO_BIT;
      st.debug_mode <= `DCS_ZERO_BIT;
      st.debug_entry <= `DCS_ZERO_BIT;
      st.ebreak_to_debug <= `DCS_ZERO_BIT;
      st.irq_block <= `DCS_ZERO_BIT;
      st.count_stop <= `DCS_ZERO_BIT;
      st.step_active <= `DCS_ZERO_BIT;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign csr_rdata = st.csr_rdata;
  assign csr_hit = st.csr_hit;
  assign csr_illegal = st.csr_illegal;
  assign debug_mode = st.debug_mode;
  assign debug_entry = st.debug_entry;
  assign ebreak_to_debug = st.ebreak_to_debug;
  assign irq_block = st.irq_block;
  assign count_stop = st.count_stop;
  assign step_active = st.step_active;

endmodule // dcs_ctrl

/* bench/dcs_ctrl_props.sv */
/*
  Checker of the debug control/status block, bound to dcs_ctrl.
  Assumes one clock, a synchronous reset, and clk_en high except while
  the hart sits halted.
*/
`timescale 1ns/1ps
module dcs_ctrl_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register access
  input wire logic clk_en,
  input wire logic csr_rd,
  input wire logic csr_wr,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  input wire logic [31:0] csr_rdata,
  input wire logic csr_hit,
  input wire logic csr_illegal,
  // Core events and hart control
  input wire logic trigger_hit,
  input wire logic ebreak_exec,
  input wire logic instr_retired,
  input wire logic step_exception,
  input wire logic debug_mode,
  input wire logic debug_entry,
  input wire logic ebreak_to_debug,
  input wire logic irq_block,
  input wire logic count_stop,
  input wire logic step_active
);
  logic [2:0] up;
  logic acc;
  assign acc = clk_en && (csr_rd || csr_wr) && csr_addr == 12'h7B0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Events are ignored during boot, so their check waits until this saturates.
  always_ff @(posedge sys_clk) begin
    if (reset)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;
  end
  chk_csr_refused: assert property (acc && !debug_mode |=> csr_illegal && !csr_hit)
    else $error("access outside halt not refused");
  chk_csr_decode: assert property (acc && debug_mode |=> csr_hit && !csr_illegal)
    else $error("halted access not accepted");
  chk_other_addr: assert property (csr_addr != 12'h7B0 |=> !csr_hit && !csr_illegal)
    else $error("other address answered");
  chk_fixed_fields: assert property (csr_hit && $past(csr_rd) |-> csr_rdata[31:28] == 4'h4 && csr_rdata[1:0] == 2'h3)
    else $error("version or privilege wrong");
  chk_zero_fields: assert property (csr_hit |-> csr_rdata[13:12] == 2'h0 && !csr_rdata[9] && !csr_rdata[4])
    else $error("hardwired zero bit set");
  chk_ebreak_bit: assert property (acc && csr_wr && debug_mode |=> ebreak_to_debug == $past(csr_wdata[15]))
    else $error("ebreak enable not taken from write");
  chk_count_stop: assert property (count_stop |-> debug_mode || $past(ebreak_exec))
    else $error("counters stopped outside debug");
  chk_irq_step: assert property (irq_block |-> step_active)
    else $error("interrupts blocked while not stepping");
  chk_step_done: assert property (step_active && (instr_retired || step_exception) |=> debug_entry && !step_active)
    else $error("step did not halt");
  chk_trig_entry: assert property (up == 3'h7 && !debug_mode && trigger_hit |=> debug_entry && debug_mode ##1 !debug_entry)
    else $error("trigger entry missing or long");
endmodule // dcs_ctrl_props

bind dcs_ctrl dcs_ctrl_props chk_i (.*);

/* bench/dcs_dbg_model.sv */
/*
  Debugger model: drives the two halt pins and the resume line.
  Assumes the bench chooses the pin and the moments to halt and resume.
*/
`timescale 1ns/1ps
module dcs_dbg_model (
  // Clock and hart state
  input wire logic sys_clk,
  input wire logic debug_mode,
  // Commands from the bench
  input wire logic want_halt,
  input wire logic use_port,
  input wire logic want_resume,
  // Lines toward the hart
  output logic dbg_halt_req,
  output logic multicore_debug_ctl_port_halt_req,
  output logic resume_req
);
  logic h, p, r;
  initial begin
    dbg_halt_req = 1'b0;
    multicore_debug_ctl_port_halt_req = 1'b0;
    resume_req = 1'b0;
  end
  // Commands are sampled on the edge so they never race the bench.
  always @(posedge sys_clk) begin
    h = want_halt;
    p = use_port;
    r = want_resume && debug_mode;
    #2;
    dbg_halt_req = h && !p;
    multicore_debug_ctl_port_halt_req = h && p;
    resume_req = r;
  end
endmodule // dcs_dbg_model

/* bench/testbench.sv */
/*
  Self-checking bench of dcs_ctrl with a debugger model on its halt lines.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic sys_clk, reset, clk_en, csr_rd, csr_wr, csr_hit, csr_illegal;
  logic [11:0] csr_addr;
  logic [31:0] csr_wdata, csr_rdata, r, d;
  logic dbg_halt_req, multicore_debug_ctl_port_halt_req, reset_halt_req, resume_req;
  logic trigger_hit, ebreak_exec, instr_retired, step_exception, nmi_pending;
  logic debug_mode, debug_entry, ebreak_to_debug, irq_block, count_stop, step_active;
  logic want_halt, use_port, want_resume;
  logic [3:0] w;
  logic [2:0] x;
  int fails, comparisons;
  integer seed;

  dcs_ctrl uut (.*);
  dcs_dbg_model dbg (.*);

  always #25 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #2;
    end
  endtask

  // An idle edge comes first, so back-to-back calls never rewrite a strobe in one time step.
  // Outputs of the access stand one cycle, so they are sampled as it returns.
  task automatic csr(input logic rd, input logic wr, input logic [11:0] a, input logic [31:0] v);
    tick(1);
    csr_rd = rd;
    csr_wr = wr;
    csr_addr = a;
    csr_wdata = v;
    tick(1);
    csr_rd = 1'b0;
    csr_wr = 1'b0;
  endtask

  task automatic wait_halt();
    int n;
    n = 0;
    while (debug_mode !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk(debug_mode, 1'b1);
  endtask

  // The write bits are ebreak enable, step interrupt enable, count stop, step.
  function automatic logic [31:0] image(input logic [3:0] v, input logic [2:0] c, input logic nmi);
    return {4'h4, 12'h000, v[3], 3'h0, v[2], v[1], 1'b0, c, 2'h0, nmi, v[0], 2'h3};
  endfunction

  function automatic logic [2:0] cause(input logic t, input logic e, input logic h, input logic s);
    if (t)
      return 3'h2;
    if (e)
      return 3'h1;
    if (h)
      return 3'h3;
    if (s)
      return 3'h4;
    return 3'h0;
  endfunction

  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end

  initial begin
    {sys_clk, csr_rd, csr_wr, csr_addr, csr_wdata, trigger_hit, ebreak_exec} = '0;
    {instr_retired, step_exception, want_halt, use_port, want_resume} = '0;
    {reset, clk_en, reset_halt_req, nmi_pending} = 4'hF;
    fails = 0;
    comparisons = 0;
    seed = 32'h2d92;
    repeat (10) @(posedge sys_clk);
    #2;
    chk({debug_mode, csr_hit, step_active}, 3'h0);
    reset = 1'b0;
    wait_halt();
    csr(1'b1, 1'b0, 12'h7B0, 32'h0);
    chk(csr_rdata, image(4'h0, 3'h5, 1'b1));
    csr(1'b1, 1'b1, 12'h7B1, 32'hFFFFFFFF);
    chk({csr_hit, csr_illegal}, 2'h0);
    csr(1'b0, 1'b1, 12'h7B0, 32'hFFFFFFFF);
    chk(count_stop, 1'b1);
    csr(1'b1, 1'b0, 12'h7B0, 32'h0);
    chk(csr_rdata, image(4'hF, 3'h5, 1'b1));
    reset_halt_req = 1'b0;
    repeat (24) begin
      r = $random(seed);
      d = $random(seed);
      w = {d[15], d[11], d[10], d[2]};
      nmi_pending = r[10];
      use_port = r[8];
      csr(1'b0, 1'b1, 12'h7B0, d);
      want_halt = r[7];
      tick(8);
      want_resume = 1'b1;
      tick(1);
      want_resume = 1'b0;
      tick(1);
      chk({step_active, irq_block}, {w[0], w[0] & !w[2]});
      trigger_hit = r[4] & r[5];
      ebreak_exec = r[6];
      step_exception = w[0] & r[9];
      instr_retired = w[0] ? !r[9] : r[3];
      x = cause(trigger_hit, ebreak_exec & w[3], r[7], w[0]);
      tick(1);
      {trigger_hit, ebreak_exec, instr_retired, step_exception} = 4'h0;
      if (x == 3'h0) begin
        tick(3);
        chk(debug_mode, 1'b0);
        csr(1'b1, 1'b0, 12'h7B0, 32'h0);
        chk(csr_illegal, 1'b1);
        chk(csr_rdata, 32'h0);
        want_halt = 1'b1;
        x = 3'h3;
      end else
        chk({debug_mode, debug_entry}, 2'h3);
      wait_halt();
      want_halt = 1'b0;
      chk({count_stop, ebreak_to_debug}, {w[1], w[3]});
      csr(1'b1, 1'b0, 12'h7B0, 32'h0);
      chk(csr_hit, 1'b1);
      chk(csr_rdata, image(w, x, r[10]));
    end
    // A write while the clock enable is low must leave every bit untouched.
    clk_en = 1'b0;
    csr(1'b0, 1'b1, 12'h7B0, ~d);
    clk_en = 1'b1;
    csr(1'b1, 1'b0, 12'h7B0, 32'h0);
    chk(csr_rdata, image(w, x, r[10]));
    report_and_stop();
  end
endmodule // testbench
